// ===== rtl/mbx_defs.svh
`ifndef MBX_DEFS_SVH
`define MBX_DEFS_SVH

// register byte offsets
`define MBX_OFF_CTRL 8'h00
`define MBX_OFF_OPCODE 8'h04
`define MBX_OFF_OPND 8'h08
`define MBX_OFF_TARGET 8'h0c
`define MBX_OFF_PC 8'h10
`define MBX_OFF_FLAGS 8'h14
`define MBX_OFF_ZPTR 8'h18
`define MBX_OFF_SP 8'h1c
`define MBX_OFF_PROD 8'h20
`define MBX_OFF_STATUS 8'h24

// operand register fields, control register go bit and opcode width
`define MBX_OPND_A 7:0
`define MBX_OPND_B 15:8
`define MBX_OPND_BIT 18:16
`define MBX_OPND_TWOWORD 19
`define MBX_CTRL_GO 0
`define MBX_OPCODE_W 6

// status flags register bit positions
`define MBX_FLAG_C 3'h0
`define MBX_FLAG_Z 3'h1
`define MBX_FLAG_N 3'h2
`define MBX_FLAG_V 3'h3
`define MBX_FLAG_S 3'h4
`define MBX_FLAG_H 3'h5
`define MBX_FLAG_T 3'h6
`define MBX_FLAG_I 3'h7

// reset values
`define MBX_PC_RST 16'h0000
`define MBX_FLAGS_RST 8'h00
`define MBX_SP_RST 4'hf
`define MBX_ZERO16 16'h0000
`define MBX_ZERO32 32'h00000000

// cycle counts
`define MBX_CYC_1 3'h1
`define MBX_CYC_2 3'h2
`define MBX_CYC_3 3'h3
`define MBX_CYC_4 3'h4

// program counter steps
`define MBX_STEP_1 16'h0001
`define MBX_STEP_2 16'h0002
`define MBX_STEP_3 16'h0003

// bus responses
`define MBX_RESP_OKAY 2'h0
`define MBX_RESP_SLVERR 2'h2

`endif

// ===== rtl/mbx_pkg.sv
package mbx_pkg;

	typedef enum logic [5:0] {
		MBX_MULTIPLY_SIGNED_BY_UNSIGNED,
		MBX_FRACTIONAL_PRODUCT_UNSIGNED,
		MBX_FRACTIONAL_PRODUCT_SIGNED,
		MBX_FRACTIONAL_PRODUCT_MIXED,
		MBX_RELATIVE_JUMP,
		MBX_POINTER_INDIRECT_JUMP,
		MBX_DIRECT_JUMP,
		MBX_RELATIVE_SUBROUTINE_CALL,
		MBX_POINTER_INDIRECT_CALL,
		MBX_DIRECT_CALL,
		MBX_SUBROUTINE_RETURN,
		MBX_INTERRUPT_RETURN,
		MBX_COMPARE_SKIP_EQUAL,
		MBX_COMPARE_PLAIN,
		MBX_COMPARE_WITH_CARRY,
		MBX_COMPARE_IMMEDIATE,
		MBX_SKIP_REG_BIT_CLEAR,
		MBX_SKIP_REG_BIT_SET,
		MBX_SKIP_IO_BIT_CLEAR,
		MBX_SKIP_IO_BIT_SET,
		MBX_BRANCH_STATUS_BIT_SET,
		MBX_BRANCH_STATUS_BIT_CLEAR,
		MBX_BRANCH_EQUAL,
		MBX_BRANCH_NOT_EQUAL,
		MBX_BRANCH_CARRY_SET,
		MBX_BRANCH_CARRY_CLEAR,
		MBX_BRANCH_SAME_OR_HIGHER,
		MBX_BRANCH_LOWER,
		MBX_BRANCH_MINUS,
		MBX_BRANCH_PLUS,
		MBX_BRANCH_GREATER_EQUAL_SIGNED,
		MBX_BRANCH_LESS_SIGNED,
		MBX_BRANCH_HALF_CARRY_SET,
		MBX_BRANCH_HALF_CARRY_CLEAR,
		MBX_BRANCH_TRANSFER_BIT_SET,
		MBX_BRANCH_TRANSFER_BIT_CLEAR,
		MBX_BRANCH_OVERFLOW_SET
	} mbx_op_e;

	typedef logic [15:0] mbx_word_t;

endpackage : mbx_pkg

// ===== rtl/mbx_mul.sv
`timescale 1ns/1ps
`include "mbx_defs.svh"

module mbx_mul
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [7:0] opA,
	input wire logic [7:0] opB,
	input wire logic aSigned,
	input wire logic bSigned,
	input wire logic fractional,
	output logic [15:0] product,
	output logic zero,
	output logic carry
);
	import mbx_pkg::*;

	logic signed [8:0] aExt;
	logic signed [8:0] bExt;
	logic signed [17:0] full;
	logic [15:0] raw;
	logic [15:0] shaped;

	// sign extension decides signed or unsigned treatment per operand
	assign aExt = {aSigned & opA[7], opA};
	assign bExt = {bSigned & opB[7], opB};
	assign full = aExt * bExt;
	assign raw = full[15:0];
	assign shaped = fractional ? {raw[14:0], 1'b0} : raw;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			product <= `MBX_ZERO16;
			zero <= 1'b0;
			carry <= 1'b0;
		end
		else if (load)
		begin
			product <= shaped;
			zero <= (shaped == `MBX_ZERO16);
			// carry reflects the top bit before the fractional shift
			carry <= raw[15];
		end
	end

endmodule : mbx_mul

// ===== rtl/mbx_core.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "mbx_defs.svh"

module mbx_core
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import mbx_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	logic [`MBX_OPCODE_W-1:0] opcode_q;
	logic [31:0] opnd_q;
	mbx_word_t target_q;
	mbx_word_t pc_q;
	logic [7:0] flags_q;
	mbx_word_t zptr_q;
	logic [3:0] sp_q;
	mbx_word_t prod_q;
	mbx_word_t stack_q [16];
	logic busy_q;
	logic [2:0] cnt_q;
	logic [2:0] lastCyc_q;
	logic lastTaken_q;
	logic wrFire;
	logic rdFire;
	logic wrOk;
	logic go;
	logic commit;
	mbx_op_e op;
	logic [7:0] opA;
	logic [7:0] opB;
	logic [2:0] bitSel;
	logic nextTwoWord;
	logic [2:0] cycles;
	mbx_word_t nextPc;
	logic [7:0] flagsNext;
	logic taken;
	logic isMul;
	logic doPush;
	logic doPop;
	mbx_word_t retAddr;
	logic [15:0] mulProd;
	logic mulZero;
	logic mulCarry;
	logic aSigned;
	logic bSigned;
	logic fractional;
	logic [8:0] diff;
	logic [7:0] res;

	//////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] mergeLanes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] merged;
		merged = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				merged[i*8 +: 8] = data[i*8 +: 8];
		end
		return merged;
	endfunction : mergeLanes

	function automatic logic isMapped(input logic [7:0] addr);
		case (addr)
			`MBX_OFF_CTRL, `MBX_OFF_OPCODE, `MBX_OFF_OPND, `MBX_OFF_TARGET,
			`MBX_OFF_PC, `MBX_OFF_FLAGS, `MBX_OFF_ZPTR, `MBX_OFF_SP,
			`MBX_OFF_PROD, `MBX_OFF_STATUS: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : isMapped

	// relative target: PC + k + 1
	function automatic mbx_word_t relTarget(input mbx_word_t pc, input mbx_word_t k);
		return mbx_word_t'(pc + k + `MBX_STEP_1);
	endfunction : relTarget

	//////////////////////////////////////////////////////////////////////////
	// bus slave: address and data taken together; both held by the master
	assign wrFire = awready & awvalid;
	assign rdFire = arready & arvalid;
	// writes are ignored while an instruction runs so operands stay stable
	assign wrOk = wrFire & isMapped(awaddr) & ~busy_q;
	assign go = wrOk & (awaddr == `MBX_OFF_CTRL) & wstrb[0] & wdata[`MBX_CTRL_GO];
	assign commit = busy_q & (cnt_q == `MBX_CYC_1);

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `MBX_RESP_OKAY;
		end
		else
		begin
			awready <= awvalid & wvalid & ~awready & ~bvalid;
			wready <= awvalid & wvalid & ~awready & ~bvalid;
			if (wrFire)
			begin
				bvalid <= 1'b1;
				bresp <= isMapped(awaddr) ? `MBX_RESP_OKAY : `MBX_RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= `MBX_ZERO32;
			rresp <= `MBX_RESP_OKAY;
		end
		else
		begin
			arready <= arvalid & ~arready & ~rvalid;
			if (rdFire)
			begin
				rvalid <= 1'b1;
				rresp <= isMapped(araddr) ? `MBX_RESP_OKAY : `MBX_RESP_SLVERR;
				case (araddr)
					`MBX_OFF_OPCODE: rdata <= {26'h0000000, opcode_q};
					`MBX_OFF_OPND: rdata <= {12'h000, opnd_q[19:0]};
					`MBX_OFF_TARGET: rdata <= {16'h0000, target_q};
					`MBX_OFF_PC: rdata <= {16'h0000, pc_q};
					`MBX_OFF_FLAGS: rdata <= {24'h000000, flags_q};
					`MBX_OFF_ZPTR: rdata <= {16'h0000, zptr_q};
					`MBX_OFF_SP: rdata <= {28'h0000000, sp_q};
					`MBX_OFF_PROD: rdata <= {16'h0000, prod_q};
					`MBX_OFF_STATUS: rdata <= {23'h000000, lastTaken_q, 4'h0,
						lastCyc_q, busy_q};
					default: rdata <= `MBX_ZERO32;
				endcase
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// software-written instruction operands
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			opcode_q <= 6'h00;
			opnd_q <= `MBX_ZERO32;
			target_q <= `MBX_ZERO16;
			zptr_q <= `MBX_ZERO16;
		end
		else if (wrOk)
		begin
			case (awaddr)
				`MBX_OFF_OPCODE: opcode_q <= `MBX_OPCODE_W'(mergeLanes({26'h0000000,
					opcode_q}, wdata, wstrb));
				`MBX_OFF_OPND: opnd_q <= mergeLanes(opnd_q, wdata, wstrb);
				`MBX_OFF_TARGET: target_q <= mbx_word_t'(mergeLanes({16'h0000, target_q},
					wdata, wstrb));
				`MBX_OFF_ZPTR: zptr_q <= mbx_word_t'(mergeLanes({16'h0000, zptr_q},
					wdata, wstrb));
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// decode and next state, evaluated from stable operand registers
	assign op = mbx_op_e'(opcode_q);
	assign opA = opnd_q[`MBX_OPND_A];
	assign opB = opnd_q[`MBX_OPND_B];
	assign bitSel = opnd_q[`MBX_OPND_BIT];
	assign nextTwoWord = opnd_q[`MBX_OPND_TWOWORD];
	// compare with carry subtracts the carry as well
	assign diff = {1'b0, opA} - {1'b0, opB}
		- {8'h00, (op == MBX_COMPARE_WITH_CARRY) & flags_q[`MBX_FLAG_C]};
	assign res = diff[7:0];

	always_comb
	begin
		cycles = `MBX_CYC_1;
		nextPc = mbx_word_t'(pc_q + `MBX_STEP_1);
		flagsNext = flags_q;
		taken = 1'b0;
		isMul = 1'b0;
		doPush = 1'b0;
		doPop = 1'b0;
		retAddr = mbx_word_t'(pc_q + `MBX_STEP_1);
		aSigned = 1'b0;
		bSigned = 1'b0;
		fractional = 1'b0;
		case (op)
			MBX_MULTIPLY_SIGNED_BY_UNSIGNED, MBX_FRACTIONAL_PRODUCT_UNSIGNED,
			MBX_FRACTIONAL_PRODUCT_SIGNED, MBX_FRACTIONAL_PRODUCT_MIXED:
			begin
				isMul = 1'b1;
				cycles = `MBX_CYC_2;
				aSigned = (op != MBX_FRACTIONAL_PRODUCT_UNSIGNED);
				bSigned = (op == MBX_FRACTIONAL_PRODUCT_SIGNED);
				fractional = (op != MBX_MULTIPLY_SIGNED_BY_UNSIGNED);
				flagsNext[`MBX_FLAG_Z] = mulZero;
				flagsNext[`MBX_FLAG_C] = mulCarry;
			end
			MBX_RELATIVE_JUMP:
			begin
				cycles = `MBX_CYC_2;
				nextPc = relTarget(pc_q, target_q);
			end
			MBX_POINTER_INDIRECT_JUMP:
			begin
				cycles = `MBX_CYC_2;
				nextPc = zptr_q;
			end
			MBX_DIRECT_JUMP:
			begin
				cycles = `MBX_CYC_3;
				nextPc = target_q;
			end
			MBX_RELATIVE_SUBROUTINE_CALL, MBX_POINTER_INDIRECT_CALL:
			begin
				cycles = `MBX_CYC_3;
				doPush = 1'b1;
				nextPc = (op == MBX_POINTER_INDIRECT_CALL) ? zptr_q
					: relTarget(pc_q, target_q);
			end
			MBX_DIRECT_CALL:
			begin
				cycles = `MBX_CYC_4;
				doPush = 1'b1;
				// two-word call returns past its address word
				retAddr = mbx_word_t'(pc_q + `MBX_STEP_2);
				nextPc = target_q;
			end
			MBX_SUBROUTINE_RETURN, MBX_INTERRUPT_RETURN:
			begin
				cycles = `MBX_CYC_4;
				doPop = 1'b1;
				nextPc = stack_q[4'(sp_q + 4'h1)];
				if (op == MBX_INTERRUPT_RETURN)
					flagsNext[`MBX_FLAG_I] = 1'b1;
			end
			MBX_COMPARE_PLAIN, MBX_COMPARE_WITH_CARRY, MBX_COMPARE_IMMEDIATE:
			begin
				// result discarded, flags only
				flagsNext[`MBX_FLAG_C] = diff[8];
				flagsNext[`MBX_FLAG_N] = res[7];
				flagsNext[`MBX_FLAG_V] = (opA[7] & ~opB[7] & ~res[7])
					| (~opA[7] & opB[7] & res[7]);
				flagsNext[`MBX_FLAG_H] = (~opA[3] & opB[3]) | (opB[3] & res[3])
					| (res[3] & ~opA[3]);
				// carry form keeps Z only when the whole chain is zero
				flagsNext[`MBX_FLAG_Z] = (res == 8'h00)
					& ((op != MBX_COMPARE_WITH_CARRY) | flags_q[`MBX_FLAG_Z]);
			end
			MBX_COMPARE_SKIP_EQUAL, MBX_SKIP_REG_BIT_CLEAR, MBX_SKIP_REG_BIT_SET,
			MBX_SKIP_IO_BIT_CLEAR, MBX_SKIP_IO_BIT_SET:
			begin
				case (op)
					MBX_COMPARE_SKIP_EQUAL: taken = (opA == opB);
					MBX_SKIP_REG_BIT_CLEAR: taken = ~opA[bitSel];
					MBX_SKIP_REG_BIT_SET: taken = opA[bitSel];
					MBX_SKIP_IO_BIT_CLEAR: taken = ~opA[bitSel];
					default: taken = opA[bitSel];
				endcase
				if (taken)
				begin
					cycles = nextTwoWord ? `MBX_CYC_3 : `MBX_CYC_2;
					nextPc = mbx_word_t'(pc_q + (nextTwoWord ? `MBX_STEP_3
						: `MBX_STEP_2));
				end
			end
			MBX_BRANCH_STATUS_BIT_SET: taken = flags_q[bitSel];
			MBX_BRANCH_STATUS_BIT_CLEAR: taken = ~flags_q[bitSel];
			MBX_BRANCH_EQUAL: taken = flags_q[`MBX_FLAG_Z];
			MBX_BRANCH_NOT_EQUAL: taken = ~flags_q[`MBX_FLAG_Z];
			MBX_BRANCH_CARRY_SET, MBX_BRANCH_LOWER:
				taken = flags_q[`MBX_FLAG_C];
			MBX_BRANCH_CARRY_CLEAR, MBX_BRANCH_SAME_OR_HIGHER:
				taken = ~flags_q[`MBX_FLAG_C];
			MBX_BRANCH_MINUS: taken = flags_q[`MBX_FLAG_N];
			MBX_BRANCH_PLUS: taken = ~flags_q[`MBX_FLAG_N];
			MBX_BRANCH_GREATER_EQUAL_SIGNED:
				taken = ~(flags_q[`MBX_FLAG_N] ^ flags_q[`MBX_FLAG_V]);
			MBX_BRANCH_LESS_SIGNED:
				taken = flags_q[`MBX_FLAG_N] ^ flags_q[`MBX_FLAG_V];
			MBX_BRANCH_HALF_CARRY_SET: taken = flags_q[`MBX_FLAG_H];
			MBX_BRANCH_HALF_CARRY_CLEAR: taken = ~flags_q[`MBX_FLAG_H];
			MBX_BRANCH_TRANSFER_BIT_SET: taken = flags_q[`MBX_FLAG_T];
			MBX_BRANCH_TRANSFER_BIT_CLEAR: taken = ~flags_q[`MBX_FLAG_T];
			MBX_BRANCH_OVERFLOW_SET: taken = flags_q[`MBX_FLAG_V];
			default: ;
		endcase
		// every conditional branch shares target and timing
		if (taken && op >= MBX_BRANCH_STATUS_BIT_SET)
		begin
			cycles = `MBX_CYC_2;
			nextPc = relTarget(pc_q, target_q);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	mbx_mul u_mul
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.load(go),
		.opA(opA),
		.opB(opB),
		.aSigned(aSigned),
		.bSigned(bSigned),
		.fractional(fractional),
		.product(mulProd),
		.zero(mulZero),
		.carry(mulCarry)
	);

	//////////////////////////////////////////////////////////////////////////
	// instruction timing: busy for exactly the instruction's cycle count
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_q <= 1'b0;
			cnt_q <= 3'h0;
			lastCyc_q <= 3'h0;
			lastTaken_q <= 1'b0;
		end
		else if (go)
		begin
			busy_q <= 1'b1;
			cnt_q <= cycles;
			lastCyc_q <= cycles;
			lastTaken_q <= taken;
		end
		else if (busy_q)
		begin
			cnt_q <= cnt_q - 3'h1;
			if (commit)
				busy_q <= 1'b0;
		end
	end

	// architectural state: software writes only while idle
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pc_q <= `MBX_PC_RST;
			flags_q <= `MBX_FLAGS_RST;
			sp_q <= `MBX_SP_RST;
			prod_q <= `MBX_ZERO16;
		end
		else if (commit)
		begin
			pc_q <= nextPc;
			flags_q <= flagsNext;
			if (isMul)
				prod_q <= mulProd;
			if (doPush)
				sp_q <= sp_q - 4'h1;
			else if (doPop)
				sp_q <= sp_q + 4'h1;
		end
		else if (wrOk)
		begin
			case (awaddr)
				`MBX_OFF_PC: pc_q <= mbx_word_t'(mergeLanes({16'h0000, pc_q}, wdata, wstrb));
				`MBX_OFF_FLAGS: flags_q <= 8'(mergeLanes({24'h000000, flags_q},
					wdata, wstrb));
				`MBX_OFF_SP: sp_q <= 4'(mergeLanes({28'h0000000, sp_q},
					wdata, wstrb));
				default: ;
			endcase
		end
	end

	// return stack; wraps silently past sixteen entries
	always_ff @(posedge core_clk)
	begin
		if (commit && doPush)
			stack_q[sp_q] <= retAddr;
	end

endmodule : mbx_core

// ===== tb/mbx_core_props.sv
`timescale 1ns/1ps

module mbx_core_props
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	//////////////////////////////////////////////////////////////////////////////
	property p_aw_w;
		awready |-> wready;
	endproperty
	a_aw_w: assert property (p_aw_w) else $error("awready without wready");
	property p_aw_pulse;
		awready |=> !awready;
	endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
	property p_aw_cause;
		$rose(awready) |-> $past(awvalid) && $past(wvalid);
	endproperty
	a_aw_cause: assert property (p_aw_cause) else $error("awready without request");
	property p_b_rise;
		awvalid && awready && wvalid && wready |=> bvalid;
	endproperty
	a_b_rise: assert property (p_b_rise) else $error("no write response");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_code;
		bvalid |-> (bresp == 2'h0 || bresp == 2'h2);
	endproperty
	a_b_code: assert property (p_b_code) else $error("bad write response code");
	property p_ar_lat;
		$rose(arvalid) && !rvalid |-> ##[1:2] arready;
	endproperty
	a_ar_lat: assert property (p_ar_lat) else $error("read address not taken");
	property p_ar_pulse;
		arready |=> !arready;
	endproperty
	a_ar_pulse: assert property (p_ar_pulse) else $error("arready longer than one cycle");
	property p_r_rise;
		arvalid && arready |=> rvalid;
	endproperty
	a_r_rise: assert property (p_r_rise) else $error("no read response");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read response dropped");
	property p_r_code;
		rvalid && rresp == 2'h2 |-> rdata == 32'h00000000;
	endproperty
	a_r_code: assert property (p_r_code) else $error("unmapped read not zero");
	c_wr: cover property (awvalid && awready);
	c_rd: cover property (arvalid && arready);
	c_err: cover property (rvalid && rresp == 2'h2);
endmodule : mbx_core_props

bind mbx_core mbx_core_props i_props (.core_clk, .resetn, .awvalid, .awready, .wvalid,
	.wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

// ===== tb/mbx_core_tb.sv
`timescale 1ns/1ps
`include "mbx_defs.svh"

module mbx_core_tb;
	import mbx_pkg::*;
	typedef struct packed {logic [7:0] op; logic [19:0] od; logic [15:0] k; logic [7:0] f;
		logic [15:0] pc; logic [7:0] fo; logic [15:0] prod; logic [3:0] cy;} mbx_row_s;
	// op, operand, target, flags in, pc, flags out, product, cycles
	mbx_row_s rows [27] = '{96'h00_002ff_0000_7e_0101_7d_fffe_2, 96'h00_00500_0000_01_0101_02_0000_2,
		96'h01_08080_0000_00_0101_00_8000_2, 96'h02_040c0_0000_40_0101_41_e000_2,
		96'h03_0ffff_0000_00_0101_01_fe02_2, 96'h04_00000_fff0_3f_00f1_3f_0000_2,
		96'h05_00000_0000_3f_0200_3f_0000_2, 96'h06_00000_1234_3f_1234_3f_0000_3,
		96'h07_00000_0010_3f_0111_3f_0000_3, 96'h08_00000_0000_3f_0200_3f_0000_3,
		96'h09_00000_1234_ff_1234_ff_0000_4, 96'h0c_00505_0000_21_0102_21_0000_2,
		96'h0c_00605_0000_21_0101_21_0000_1, 96'h0c_80505_0000_21_0103_21_0000_3,
		96'h0d_02010_0000_c0_0101_c5_0000_1, 96'h0d_00180_0000_00_0101_28_0000_1,
		96'h0e_00505_0000_03_0101_25_0000_1, 96'h0e_00405_0000_03_0101_02_0000_1,
		96'h0f_03333_0000_00_0101_02_0000_1, 96'h10_300f7_0000_55_0102_55_0000_2,
		96'h11_b0008_0000_55_0103_55_0000_3, 96'h11_300f7_0000_55_0101_55_0000_1,
		96'h12_70000_0000_55_0102_55_0000_2, 96'h13_7007f_0000_55_0101_55_0000_1,
		96'h13_f0080_0000_55_0103_55_0000_3, 96'h10_00001_0000_55_0101_55_0000_1,
		96'h25_00000_0000_55_0101_55_0000_1};
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, d;
	int miscompares = 0, samples_checked = 0;

	always #5 core_clk = ~core_clk;

	mbx_core i_dut (.core_clk, .resetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
		.wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	//////////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task hang;
		miscompares++;
		$display("wrong value at %0t: no answer", $time);
		stop_test();
	endtask : hang

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask : chk

	// lag holds bready back so the response must stand
	task wr(input logic [7:0] a, input logic [31:0] v, input int lag = 0);
		int n;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (lag == 0);
		for (n = 0; n < 40; n++)
		begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (n == lag) bready <= 1'b1;
		end
		if (n == 40) hang();
		rsp = bresp;
		bready <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	task rd(input logic [7:0] a, input int lag = 0);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		for (n = 0; n < 40; n++)
		begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (n == lag) rready <= 1'b1;
		end
		if (n == 40) hang();
		d = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge core_clk);
	endtask : rd

	// every instruction starts from pc 0x0100
	task ex(input logic [7:0] op, input logic [19:0] od, input logic [15:0] k,
		input logic [7:0] f, input logic [15:0] pc, input logic [7:0] fo, input logic [3:0] cy);
		int n;
		wr(`MBX_OFF_OPCODE, 32'(op));
		wr(`MBX_OFF_OPND, 32'(od));
		wr(`MBX_OFF_TARGET, 32'(k));
		wr(`MBX_OFF_FLAGS, 32'(f));
		wr(`MBX_OFF_PC, 32'h00000100);
		wr(`MBX_OFF_CTRL, 32'h00000001);
		chk(32'(rsp), 32'(`MBX_RESP_OKAY));
		for (n = 0; n < 20; n++)
		begin
			rd(`MBX_OFF_STATUS);
			if (d[0] === 1'b0) break;
		end
		if (n == 20) hang();
		chk(32'(d[3:1]), 32'(cy));
		// only skips and branches report taken, and only when they took longer than one cycle
		chk(32'(d[8]), 32'(op >= 8'h0c && op <= 8'h24 && cy > 4'h1));
		rd(`MBX_OFF_PC);
		chk(32'(rsp), 32'(`MBX_RESP_OKAY));
		chk(d, 32'(pc));
		rd(`MBX_OFF_FLAGS);
		chk(d, 32'(fo));
	endtask : ex

	function automatic logic taken(input int o, input logic [7:0] f, input int s);
		case (o)
			20: return f[s];
			21: return !f[s];
			22: return f[1];
			23: return !f[1];
			24, 27: return f[0];
			25, 26: return !f[0];
			28: return f[2];
			29: return !f[2];
			30: return !(f[2] ^ f[3]);
			31: return f[2] ^ f[3];
			32: return f[5];
			33: return !f[5];
			34: return f[6];
			35: return !f[6];
			default: return f[3];
		endcase
	endfunction : taken

	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [7:0] f;
		logic t;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rd(`MBX_OFF_PC, 3);
		chk(d, 32'h00000000);
		rd(`MBX_OFF_SP);
		chk(d, 32'h0000000f);
		rd(`MBX_OFF_STATUS);
		chk(d, 32'h00000000);
		wr(`MBX_OFF_ZPTR, 32'h00000200, 2);
		foreach (rows[i])
		begin
			ex(rows[i].op, rows[i].od, rows[i].k, rows[i].f, rows[i].pc, rows[i].fo, rows[i].cy);
			rd(`MBX_OFF_PROD);
			if (rows[i].op < 8'h04) chk(d, 32'(rows[i].prod));
		end
		// one flag at a time, then N and V together for the signed pair
		for (int o = 20; o <= 36; o++)
			for (int i = 0; i < 9; i++)
			begin
				f = (i < 8) ? 8'h01 << i : 8'h0c;
				t = taken(o, f, i % 8);
				ex(8'(o), {1'b0, 3'(i), 16'h0000}, 16'hff00, f, t ? 16'h0001 : 16'h0101, f,
					t ? 4'h2 : 4'h1);
			end
		// nested calls unwind last in, first out
		wr(`MBX_OFF_SP, 32'h0000000f);
		ex(8'h07, 20'h00000, 16'h0010, 8'h00, 16'h0111, 8'h00, 4'h3);
		ex(8'h09, 20'h00000, 16'h1234, 8'h00, 16'h1234, 8'h00, 4'h4);
		rd(`MBX_OFF_SP);
		chk(d, 32'h0000000d);
		ex(8'h0a, 20'h00000, 16'h0000, 8'h05, 16'h0102, 8'h05, 4'h4);
		ex(8'h0b, 20'h00000, 16'h0000, 8'h05, 16'h0101, 8'h85, 4'h4);
		rd(`MBX_OFF_SP);
		chk(d, 32'h0000000f);
		// a write landing while an instruction runs is answered but dropped
		wr(`MBX_OFF_TARGET, 32'h00000abc);
		wr(`MBX_OFF_OPCODE, 32'h00000009);
		wr(`MBX_OFF_CTRL, 32'h00000001);
		wr(`MBX_OFF_PC, 32'h00000777);
		chk(32'(rsp), 32'(`MBX_RESP_OKAY));
		rd(`MBX_OFF_PC);
		chk(d, 32'h00000abc);
		rd(8'h40);
		chk(d, 32'h00000000);
		chk(32'(rsp), 32'(`MBX_RESP_SLVERR));
		wr(8'h40, 32'h00000001);
		chk(32'(rsp), 32'(`MBX_RESP_SLVERR));
		rd(`MBX_OFF_CTRL);
		chk(d, 32'h00000000);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rd(`MBX_OFF_PC);
		chk(d, 32'h00000000);
		rd(`MBX_OFF_SP);
		chk(d, 32'h0000000f);
		stop_test();
	end
endmodule : mbx_core_tb
